// ### pkg/rf_front_map.vh
// Purpose: Register offsets, reset values, field positions and code constants
//          for the RF power and signal-strength control block.
// Assumes: 7-bit register addresses and 8-bit data on the serial port.
// Notes:   Included by bare name from the control rtl file and the testbench.
`ifndef RF_FRONT_MAP_VH
`define RF_FRONT_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_AMP_CONFIG 7'h09
`define OFF_OVERCURRENT 7'h0b
`define OFF_STRENGTH_CONFIG 7'h0e
`define OFF_STRENGTH_THRESH 7'h10
`define OFF_STRENGTH_READING 7'h11
`define OFF_CALIBRATION 7'h3b
`define OFF_RX_STATUS 7'h3f
`define OFF_BOOST_POWER 7'h4d
`define OFF_GAIN_THRESH_BASE 7'h62

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_AMP_CONFIG 8'h4f
`define RST_OVERCURRENT 8'h2b
`define RST_STRENGTH_CONFIG 8'h02
`define RST_STRENGTH_THRESH 8'he4
`define RST_BOOST_POWER 8'h84
`define RST_GAIN_THRESH_1 8'hb0
`define RST_GAIN_THRESH_2 8'hba
`define RST_GAIN_THRESH_3 8'hc4
`define RST_GAIN_THRESH_4 8'hce
`define RST_GAIN_THRESH_5 8'hd8

// ----------------------------------------
// Fields and codes
// ----------------------------------------
`define BOOST_HIGH_POWER 8'h87
`define AMP_SELECT_BIT 7
`define OCP_ENABLE_BIT 5
`define CAL_START_BIT 6
`define OCP_SPLIT_CODE 5'h0f
`define OCP_TOP_CODE 5'h1b
`define OCP_LOW_BASE_MA 8'h2d
`define OCP_LOW_STEP_MA 8'h05
`define OCP_HIGH_BASE_MA 8'h1e
`define OCP_HIGH_STEP_MA 8'h0a
`define OCP_MAX_MA 8'hf0
`define GAIN_G1 3'h1
`define GAIN_G2 3'h2
`define GAIN_G3 3'h3
`define GAIN_G4 3'h4
`define GAIN_G5 3'h6
`define GAIN_G6 3'h7

`endif

// ### rtl/strength_averager.v
// Purpose: Running average of signal-strength samples over 2^(code+1) samples.
// Assumes: One sample per sample_valid_in pulse, same clock as the caller.
// Notes:   Exponential average; response time scales with the sample count.
module strength_averager #(
  parameter WIDTH = 8,
  parameter CODE_WIDTH = 3
) (
  input wire clock_in,
  input wire rst_b_in,
  input wire sample_valid_in,
  input wire [WIDTH-1:0] sample_in,
  input wire [CODE_WIDTH-1:0] avg_code_in,
  input wire restart_in,
  output wire [WIDTH-1:0] average_out
);
  localparam ACC_WIDTH = 2 * WIDTH;
  reg [ACC_WIDTH-1:0] acc_reg;
  reg [ACC_WIDTH-1:0] acc_next;
  reg [CODE_WIDTH-1:0] code_reg;
  reg primed_reg;
  reg primed_next;
  wire [3:0] shift;
  wire [ACC_WIDTH-1:0] sample_wide;
  wire [ACC_WIDTH-1:0] acc_scaled;

  // Window of 2^(code+1) samples
  assign shift = {1'b0, avg_code_in} + 4'h1;
  assign sample_wide = {{WIDTH{1'b0}}, sample_in};
  // Once primed at the current code, accumulator stays within sample_max << shift, so the low bits hold the whole mean
  assign acc_scaled = acc_reg >> shift;
  assign average_out = acc_scaled[WIDTH-1:0];

  always @* begin
    acc_next = acc_reg;
    primed_next = primed_reg;
    // Code change or calibration restarts; avoids a stale scale factor
    if (restart_in || code_reg != avg_code_in) begin
      primed_next = 1'b0;
    end else if (sample_valid_in) begin
      if (!primed_reg) begin
        acc_next = sample_wide << shift;
        primed_next = 1'b1;
      end else begin
        acc_next = acc_reg - (acc_reg >> shift) + sample_wide;
      end
    end
  end

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acc_reg <= {ACC_WIDTH{1'b0}};
      code_reg <= {CODE_WIDTH{1'b0}};
      primed_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      code_reg <= avg_code_in;
      primed_reg <= primed_next;
    end
  end
endmodule // strength_averager

// ### rtl/rf_power_and_rssi_control.v
// Purpose: Serial register port, boost power, current ceiling, receiver states,
//          gain selection and signal-strength reading.
// Assumes: Serial pins are asynchronous; front-end inputs share clock_in.
// Notes:   Serial clock must be well below clock_in/6 for the pin filters.
`include "rf_front_map.vh"
module rf_power_and_rssi_control (
  input wire clock_in,
  input wire rst_b_in,
  input wire select_b_in,
  input wire sck_in,
  input wire mosi_in,
  output reg miso_out,
  output reg miso_oe_out,
  input wire rx_mode_in,
  input wire preamble_valid_in,
  input wire level_valid_in,
  input wire [7:0] level_dbm_in,
  output reg [2:0] input_amp_gain_code_out,
  output reg amp_output_select_out,
  output reg boost_max_power_out,
  output reg overcurrent_enable_out,
  output reg [7:0] pa_current_limit_ma_out,
  output reg rx_enabled_out,
  output reg rx_active_out
);
  localparam RX_IDLE = 2'h0;
  localparam RX_ENABLED = 2'h1;
  localparam RX_ACTIVE = 2'h2;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [7:0] ocp_limit;
    input [4:0] trim;
    begin
      if (trim <= `OCP_SPLIT_CODE) begin
        ocp_limit = `OCP_LOW_BASE_MA + `OCP_LOW_STEP_MA * {3'h0, trim};
      end else if (trim <= `OCP_TOP_CODE) begin
        ocp_limit = `OCP_HIGH_STEP_MA * {3'h0, trim} - `OCP_HIGH_BASE_MA;
      end else begin
        ocp_limit = `OCP_MAX_MA;
      end
    end
  endfunction

  function [2:0] gain_pick;
    input signed [7:0] lvl;
    input [39:0] th;
    begin
      if (lvl <= $signed(th[7:0])) begin
        gain_pick = `GAIN_G1;
      end else if (lvl <= $signed(th[15:8])) begin
        gain_pick = `GAIN_G2;
      end else if (lvl <= $signed(th[23:16])) begin
        gain_pick = `GAIN_G3;
      end else if (lvl <= $signed(th[31:24])) begin
        gain_pick = `GAIN_G4;
      end else if (lvl <= $signed(th[39:32])) begin
        gain_pick = `GAIN_G5;
      end else begin
        gain_pick = `GAIN_G6;
      end
    end
  endfunction

  // ----------------------------------------
  // Pin filters
  // ----------------------------------------
  reg [2:0] sel_sync_reg;
  reg [2:0] sck_sync_reg;
  reg [2:0] mosi_sync_reg;
  reg sel_f_reg;
  reg sck_f_reg;
  reg mosi_f_reg;
  wire sel_fall;
  wire sel_rise;
  wire sck_rise;
  wire sck_fall;

  assign sel_fall = sel_f_reg && sel_sync_reg[2] == sel_sync_reg[1] && !sel_sync_reg[2];
  assign sel_rise = !sel_f_reg && sel_sync_reg[2] == sel_sync_reg[1] && sel_sync_reg[2];
  assign sck_rise = !sck_f_reg && sck_sync_reg[2] == sck_sync_reg[1] && sck_sync_reg[2];
  assign sck_fall = sck_f_reg && sck_sync_reg[2] == sck_sync_reg[1] && !sck_sync_reg[2];

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sel_sync_reg <= 3'h7;
      sck_sync_reg <= 3'h0;
      mosi_sync_reg <= 3'h0;
      sel_f_reg <= 1'b1;
      sck_f_reg <= 1'b0;
      mosi_f_reg <= 1'b0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[1:0], select_b_in};
      sck_sync_reg <= {sck_sync_reg[1:0], sck_in};
      mosi_sync_reg <= {mosi_sync_reg[1:0], mosi_in};
      if (sel_sync_reg[2] == sel_sync_reg[1]) begin
        sel_f_reg <= sel_sync_reg[2];
      end
      if (sck_sync_reg[2] == sck_sync_reg[1]) begin
        sck_f_reg <= sck_sync_reg[2];
      end
      if (mosi_sync_reg[2] == mosi_sync_reg[1]) begin
        mosi_f_reg <= mosi_sync_reg[2];
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] amp_config_reg;
  reg [7:0] overcurrent_reg;
  reg [7:0] strength_config_reg;
  reg [7:0] strength_thresh_reg;
  reg [7:0] boost_power_level_reg;
  reg [39:0] gain_thresh_reg;
  reg [1:0] rx_state_reg;
  reg [1:0] rx_state_next;
  wire [7:0] strength_reading;
  reg cal_start_reg;

  function [7:0] read_reg;
    input [6:0] a;
    begin
      case (a)
        `OFF_AMP_CONFIG: read_reg = amp_config_reg;
        `OFF_OVERCURRENT: read_reg = overcurrent_reg;
        `OFF_STRENGTH_CONFIG: read_reg = strength_config_reg;
        `OFF_STRENGTH_THRESH: read_reg = strength_thresh_reg;
        `OFF_STRENGTH_READING: read_reg = strength_reading;
        `OFF_RX_STATUS: read_reg = {6'h00, rx_state_reg};
        `OFF_BOOST_POWER: read_reg = boost_power_level_reg;
        `OFF_GAIN_THRESH_BASE: read_reg = gain_thresh_reg[7:0];
        `OFF_GAIN_THRESH_BASE + 7'h1: read_reg = gain_thresh_reg[15:8];
        `OFF_GAIN_THRESH_BASE + 7'h2: read_reg = gain_thresh_reg[23:16];
        `OFF_GAIN_THRESH_BASE + 7'h3: read_reg = gain_thresh_reg[31:24];
        `OFF_GAIN_THRESH_BASE + 7'h4: read_reg = gain_thresh_reg[39:32];
        default: read_reg = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Serial slave
  // ----------------------------------------
  reg [2:0] bit_cnt_reg;
  reg [7:0] rx_shift_reg;
  reg [7:0] tx_shift_reg;
  reg [6:0] addr_reg;
  reg write_reg;
  reg have_addr_reg;
  wire [7:0] rx_byte;
  wire byte_done;
  wire do_write;

  assign rx_byte = {rx_shift_reg[6:0], mosi_f_reg};
  assign byte_done = sck_rise && !sel_f_reg && bit_cnt_reg == 3'h7;
  assign do_write = byte_done && have_addr_reg && write_reg;

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bit_cnt_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      addr_reg <= 7'h00;
      write_reg <= 1'b0;
      have_addr_reg <= 1'b0;
      miso_out <= 1'b0;
      miso_oe_out <= 1'b0;
    end else begin
      if (sel_fall) begin
        bit_cnt_reg <= 3'h0;
        have_addr_reg <= 1'b0;
        tx_shift_reg <= 8'h00;
        miso_out <= 1'b0;
        miso_oe_out <= 1'b1;
      end else if (sel_rise) begin
        miso_oe_out <= 1'b0;
      end else if (!sel_f_reg) begin
        if (sck_rise) begin
          rx_shift_reg <= rx_byte;
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
        if (byte_done && !have_addr_reg) begin
          write_reg <= rx_byte[7];
          addr_reg <= rx_byte[6:0];
          have_addr_reg <= 1'b1;
          tx_shift_reg <= read_reg(rx_byte[6:0]);
        end else if (byte_done) begin
          // Burst: next address preloaded; during a write the old value shifts out
          addr_reg <= addr_reg + 7'h1;
          tx_shift_reg <= read_reg(addr_reg + 7'h1);
        end else if (sck_fall) begin
          miso_out <= tx_shift_reg[7];
          tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
        end
      end
    end
  end

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      amp_config_reg <= `RST_AMP_CONFIG;
      overcurrent_reg <= `RST_OVERCURRENT;
      strength_config_reg <= `RST_STRENGTH_CONFIG;
      strength_thresh_reg <= `RST_STRENGTH_THRESH;
      boost_power_level_reg <= `RST_BOOST_POWER;
      gain_thresh_reg <= {`RST_GAIN_THRESH_5, `RST_GAIN_THRESH_4, `RST_GAIN_THRESH_3,
                          `RST_GAIN_THRESH_2, `RST_GAIN_THRESH_1};
      cal_start_reg <= 1'b0;
    end else begin
      cal_start_reg <= do_write && addr_reg == `OFF_CALIBRATION && rx_byte[`CAL_START_BIT];
      if (do_write) begin
        case (addr_reg)
          `OFF_AMP_CONFIG: amp_config_reg <= rx_byte;
          `OFF_OVERCURRENT: overcurrent_reg <= rx_byte;
          `OFF_STRENGTH_CONFIG: strength_config_reg <= rx_byte;
          `OFF_STRENGTH_THRESH: strength_thresh_reg <= rx_byte;
          `OFF_BOOST_POWER: boost_power_level_reg <= rx_byte;
          `OFF_GAIN_THRESH_BASE: gain_thresh_reg[7:0] <= rx_byte;
          `OFF_GAIN_THRESH_BASE + 7'h1: gain_thresh_reg[15:8] <= rx_byte;
          `OFF_GAIN_THRESH_BASE + 7'h2: gain_thresh_reg[23:16] <= rx_byte;
          `OFF_GAIN_THRESH_BASE + 7'h3: gain_thresh_reg[31:24] <= rx_byte;
          `OFF_GAIN_THRESH_BASE + 7'h4: gain_thresh_reg[39:32] <= rx_byte;
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Signal strength
  // ----------------------------------------
  wire signed [10:0] raw_sample;
  wire [7:0] strength_sample;

  // Offset is signed 5 bits, -16..+15 half-dB steps (-8..+7.5 dB); clamp keeps reading in range
  assign raw_sample = -({{3{level_dbm_in[7]}}, level_dbm_in} <<< 1)
                      + {{6{strength_config_reg[7]}}, strength_config_reg[7:3]};
  assign strength_sample = raw_sample[10] ? 8'h00 :
                           (raw_sample[9:8] != 2'h0 ? 8'hff : raw_sample[7:0]);

  strength_averager #(
    .WIDTH(8),
    .CODE_WIDTH(3)
  ) u_avg (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .sample_valid_in(level_valid_in),
    .sample_in(strength_sample),
    .avg_code_in(strength_config_reg[2:0]),
    .restart_in(cal_start_reg),
    .average_out(strength_reading)
  );

  // ----------------------------------------
  // Receiver states
  // ----------------------------------------
  always @* begin
    case (rx_state_reg)
      RX_IDLE: rx_state_next = rx_mode_in ? RX_ENABLED : RX_IDLE;
      RX_ENABLED: begin
        if (!rx_mode_in) begin
          rx_state_next = RX_IDLE;
        end else if (preamble_valid_in || strength_reading <= strength_thresh_reg) begin
          rx_state_next = RX_ACTIVE;
        end else begin
          rx_state_next = RX_ENABLED;
        end
      end
      RX_ACTIVE: rx_state_next = rx_mode_in ? RX_ACTIVE : RX_IDLE;
      default: rx_state_next = RX_IDLE;
    endcase
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_state_reg <= RX_IDLE;
      rx_enabled_out <= 1'b0;
      rx_active_out <= 1'b0;
      input_amp_gain_code_out <= `GAIN_G1;
      amp_output_select_out <= 1'b0;
      boost_max_power_out <= 1'b0;
      overcurrent_enable_out <= 1'b0;
      pa_current_limit_ma_out <= 8'h00;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_enabled_out <= rx_state_next == RX_ENABLED;
      rx_active_out <= rx_state_next == RX_ACTIVE;
      if (level_valid_in) begin
        input_amp_gain_code_out <= gain_pick(level_dbm_in, gain_thresh_reg);
      end
      amp_output_select_out <= amp_config_reg[`AMP_SELECT_BIT];
      boost_max_power_out <= boost_power_level_reg == `BOOST_HIGH_POWER;
      overcurrent_enable_out <= overcurrent_reg[`OCP_ENABLE_BIT];
      // Ceiling applies to amplifier supply only, not synthesizer
      pa_current_limit_ma_out <= ocp_limit(overcurrent_reg[4:0]);
    end
  end
endmodule // rf_power_and_rssi_control

// ### dv/rf_control_monitor.sv
// Purpose: Port-level timing checks of the RF power and strength block
// Assumes: Gain thresholds stay at their reset values
// Notes: Attached to every instance of the top module by bind
module rf_control_monitor (
  input logic clock_in,
  input logic rst_b_in,
  input logic rx_mode_in,
  input logic preamble_valid_in,
  input logic level_valid_in,
  input logic [7:0] level_dbm_in,
  input logic [2:0] input_amp_gain_code_out,
  input logic [7:0] pa_current_limit_ma_out,
  input logic rx_enabled_out,
  input logic rx_active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  chk_limit_legal: assert property (
    $past(rst_b_in) |-> (pa_current_limit_ma_out inside {[8'h2d:8'h78]} &&
    pa_current_limit_ma_out % 8'h05 == 8'h00) || (pa_current_limit_ma_out inside
    {[8'h82:8'hf0]} && pa_current_limit_ma_out % 8'h0a == 8'h00))
    else $error("current ceiling outside the trim table");
  chk_gain_legal: assert property (
    input_amp_gain_code_out inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7})
    else $error("gain code not one of the six");
  chk_gain_holds: assert property (
    !level_valid_in |=> $stable(input_amp_gain_code_out))
    else $error("gain code moved without a level sample");
  chk_gain_floor: assert property (
    level_valid_in && level_dbm_in == 8'h80 |=> input_amp_gain_code_out == 3'h1)
    else $error("weakest level did not pick full gain");
  chk_gain_ceiling: assert property (
    level_valid_in && level_dbm_in == 8'h7f |=> input_amp_gain_code_out == 3'h7)
    else $error("strongest level did not pick lowest gain");
  chk_rx_idle: assert property (
    !rx_mode_in |=> !rx_enabled_out && !rx_active_out)
    else $error("receiver state shown outside receive mode");
  chk_rx_enter: assert property (
    $rose(rx_mode_in) |=> rx_enabled_out && !rx_active_out)
    else $error("receiver did not start in the waiting state");
  chk_active_cause: assert property (
    rx_active_out |-> $past(rx_mode_in))
    else $error("receiver active without receive mode");
  chk_preamble_active: assert property (
    rx_mode_in && rx_enabled_out && preamble_valid_in |-> ##[1:3]
    (rx_active_out || !rx_mode_in))
    else $error("preamble did not make the receiver active");
endmodule // rf_control_monitor

bind rf_power_and_rssi_control rf_control_monitor rf_control_monitor_i (
  .clock_in(clock_in), .rst_b_in(rst_b_in), .rx_mode_in(rx_mode_in),
  .preamble_valid_in(preamble_valid_in), .level_valid_in(level_valid_in),
  .level_dbm_in(level_dbm_in), .input_amp_gain_code_out(input_amp_gain_code_out),
  .pa_current_limit_ma_out(pa_current_limit_ma_out), .rx_enabled_out(rx_enabled_out),
  .rx_active_out(rx_active_out));

// ### dv/serial_host.sv
// Purpose: Host processor model on the register serial port
// Assumes: Serial half period is HALF reference clocks, well above the pin filters
// Notes: Data line idles at the inverse of its last bit; serial clock is still between frames
module serial_host #(
  parameter int HALF = 8
) (
  input wire logic clock_in,
  input wire logic miso_in,
  output logic select_b_out,
  output logic sck_out,
  output logic mosi_out,
  output logic rd_valid_out,
  output logic [7:0] rd_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    select_b_out = 1'b1;
    sck_out = 1'b0;
    mosi_out = 1'b0;
    rd_valid_out = 1'b0;
    rd_data_out = 8'h00;
  end
  // Launch while clock is low, sample return data just before the rise
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] data);
    logic [15:0] sh;
    logic [7:0] rx;
    sh = {cmd, data};
    rx = 8'h00;
    @(posedge clock_in);
    select_b_out <= 1'b0;
    repeat (HALF) @(posedge clock_in);
    for (int i = 15; i >= 0; i--) begin
      mosi_out <= sh[i];
      repeat (HALF) @(posedge clock_in);
      if (i < 8) rx = {rx[6:0], miso_in};
      sck_out <= 1'b1;
      repeat (HALF) @(posedge clock_in);
      sck_out <= 1'b0;
    end
    repeat (HALF) @(posedge clock_in);
    select_b_out <= 1'b1;
    mosi_out <= ~mosi_out;
    rd_data_out <= rx;
    rd_valid_out <= 1'b1;
    @(posedge clock_in);
    rd_valid_out <= 1'b0;
    repeat (HALF) @(posedge clock_in);
  endtask
endmodule // serial_host

// ### dv/testbench.sv
// Purpose: Self-checking bench for the RF power and strength control block
// Assumes: Gain thresholds are left at their reset values
// Notes: Drivers queue expected values; a watcher compares them as results appear
`include "rf_front_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic rx_mode_in = 1'b0;
  logic preamble_valid_in = 1'b0;
  logic level_valid_in = 1'b0;
  logic [7:0] level_dbm_in = 8'h00;
  logic lv_seen = 1'b0;
  logic miso_hold = 1'b0;
  wire select_b, sck, mosi, miso, miso_oe, rd_valid, amp_sel, boost, ocp_en, rx_en, rx_act;
  wire [2:0] gain;
  wire [7:0] rd_data, limit;
  wire miso_line = miso_oe ? miso : miso_hold;
  int miscompares = 0;
  int checks = 0;
  int n;
  int old;
  logic [8:0] rq[$];
  logic [2:0] gq[$];
  logic [8:0] e;
  logic [6:0] ra [6] = '{`OFF_AMP_CONFIG, `OFF_OVERCURRENT, `OFF_STRENGTH_CONFIG,
    `OFF_STRENGTH_THRESH, `OFF_BOOST_POWER, 7'h20};
  logic [7:0] rv [6] = '{`RST_AMP_CONFIG, `RST_OVERCURRENT, `RST_STRENGTH_CONFIG,
    `RST_STRENGTH_THRESH, `RST_BOOST_POWER, 8'h00};
  logic [7:0] tv [5] = '{`RST_GAIN_THRESH_1, `RST_GAIN_THRESH_2, `RST_GAIN_THRESH_3,
    `RST_GAIN_THRESH_4, `RST_GAIN_THRESH_5};
  rf_power_and_rssi_control rf_power_and_rssi_control_i (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .select_b_in(select_b), .sck_in(sck),
    .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe), .rx_mode_in(rx_mode_in),
    .preamble_valid_in(preamble_valid_in), .level_valid_in(level_valid_in),
    .level_dbm_in(level_dbm_in), .input_amp_gain_code_out(gain),
    .amp_output_select_out(amp_sel), .boost_max_power_out(boost),
    .overcurrent_enable_out(ocp_en), .pa_current_limit_ma_out(limit),
    .rx_enabled_out(rx_en), .rx_active_out(rx_act));
  serial_host serial_host_i (.clock_in(clock_in), .miso_in(miso_line), .select_b_out(select_b),
    .sck_out(sck), .mosi_out(mosi), .rd_valid_out(rd_valid), .rd_data_out(rd_data));
  always #12.5 clock_in = ~clock_in;
  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(posedge clock_in) begin
    lv_seen <= level_valid_in;
    if (miso_oe) miso_hold <= ~miso;
    if (lv_seen) check({5'h00, gain}, {5'h00, gq.pop_front()});
    if (rd_valid) begin
      e = rq.pop_front();
      if (!e[8]) check(rd_data, e[7:0]);
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] x);
    rq.push_back({1'b0, x});
    serial_host_i.xfer({1'b0, a}, 8'h00);
  endtask
  // Old contents come back during a write; 9'h100 means do not care
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [8:0] x);
    rq.push_back(x);
    serial_host_i.xfer({1'b1, a}, d);
  endtask
  function automatic logic [2:0] gexp(input logic signed [7:0] l);
    if (l <= $signed(`RST_GAIN_THRESH_1)) return `GAIN_G1;
    if (l <= $signed(`RST_GAIN_THRESH_2)) return `GAIN_G2;
    if (l <= $signed(`RST_GAIN_THRESH_3)) return `GAIN_G3;
    if (l <= $signed(`RST_GAIN_THRESH_4)) return `GAIN_G4;
    if (l <= $signed(`RST_GAIN_THRESH_5)) return `GAIN_G5;
    return `GAIN_G6;
  endfunction
  task automatic lvl(input logic [7:0] l);
    @(posedge clock_in);
    level_valid_in <= 1'b1;
    level_dbm_in <= l;
    gq.push_back(gexp(l));
    @(posedge clock_in);
    level_valid_in <= 1'b0;
  endtask
  task automatic wait_active();
    for (n = 0; n < 40 && rx_act !== 1'b1; n++) @(posedge clock_in);
    check({7'h00, rx_act}, 8'h01);
    if (n == 40) stop_test();
  endtask
  initial begin
    #2000000;
    miscompares++;
    stop_test();
  end
  initial begin
    void'($urandom(63));
    repeat (6) @(posedge clock_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    check({6'h00, amp_sel, boost}, 8'h00);
    check({7'h00, ocp_en}, 8'h01);
    check(limit, 8'h64);
    for (int k = 0; k < 6; k++) rd(ra[k], rv[k]);
    for (int k = 0; k < 5; k++) rd(7'(`OFF_GAIN_THRESH_BASE + k), tv[k]);
    check({7'h00, miso_oe}, 8'h00);
    wr(`OFF_BOOST_POWER, `BOOST_HIGH_POWER, `RST_BOOST_POWER);
    check({7'h00, boost}, 8'h01);
    rd(`OFF_BOOST_POWER, `BOOST_HIGH_POWER);
    wr(`OFF_BOOST_POWER, 8'h86, `BOOST_HIGH_POWER);
    check({7'h00, boost}, 8'h00);
    wr(`OFF_BOOST_POWER, `RST_BOOST_POWER, 8'h86);
    wr(`OFF_AMP_CONFIG, 8'hcf, `RST_AMP_CONFIG);
    check({7'h00, amp_sel}, 8'h01);
    old = `RST_OVERCURRENT;
    for (int t = 0; t < 32; t++) begin
      wr(`OFF_OVERCURRENT, 8'h20 | 8'(t), 9'(old));
      old = 8'h20 | t;
      check(limit, 8'(t <= 15 ? 45 + 5 * t : t <= 27 ? 10 * t - 30 : 240));
      check({7'h00, ocp_en}, 8'h01);
    end
    wr(`OFF_OVERCURRENT, 8'h0b, 9'(old));
    check({7'h00, ocp_en}, 8'h00);
    for (int k = 0; k < 5; k++) begin
      lvl(tv[k]);
      lvl(tv[k] + 8'h01);
    end
    lvl(8'h80);
    lvl(8'h7f);
    repeat (30) lvl(8'($urandom));
    wr(`OFF_STRENGTH_CONFIG, 8'h00, `RST_STRENGTH_CONFIG);
    repeat (16) lvl(8'hce);
    rd(`OFF_STRENGTH_READING, 8'h64);
    wr(`OFF_STRENGTH_CONFIG, 8'h78, 8'h00);
    repeat (16) lvl(8'hce);
    rd(`OFF_STRENGTH_READING, 8'h73);
    wr(`OFF_STRENGTH_CONFIG, 8'h80, 8'h78);
    repeat (16) lvl(8'hce);
    rd(`OFF_STRENGTH_READING, 8'h54);
    wr(`OFF_CALIBRATION, 8'h40, 9'h100);
    lvl(8'he2);
    rd(`OFF_STRENGTH_READING, 8'h2c);
    old = 8'h80;
    for (int c = 7; c >= 0; c--) begin
      wr(`OFF_STRENGTH_CONFIG, 8'(c), 9'(old));
      old = c;
      lvl(8'hce);
      lvl(8'hf6);
      rd(`OFF_STRENGTH_READING, 8'(((100 << (c + 1)) - 80) >> (c + 1)));
    end
    wr(`OFF_STRENGTH_THRESH, 8'h00, `RST_STRENGTH_THRESH);
    @(posedge clock_in) rx_mode_in <= 1'b1;
    repeat (12) @(posedge clock_in);
    check({6'h00, rx_act, rx_en}, 8'h01);
    rd(`OFF_RX_STATUS, 8'h01);
    @(posedge clock_in) preamble_valid_in <= 1'b1;
    @(posedge clock_in) preamble_valid_in <= 1'b0;
    wait_active();
    rd(`OFF_RX_STATUS, 8'h02);
    @(posedge clock_in) rx_mode_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    check({6'h00, rx_act, rx_en}, 8'h00);
    wr(`OFF_STRENGTH_THRESH, 8'hff, 8'h00);
    @(posedge clock_in) rx_mode_in <= 1'b1;
    wait_active();
    repeat (4) @(posedge clock_in);
    stop_test();
  end
endmodule // testbench
